/* scds_pkg.sv */
// package for the serial clock divider select block
// assumes a single clock domain and a wishbone classic register port
package scds_pkg;
    localparam logic [15:0] SCDS_REG_OFFSET = 16'hff43;
    localparam logic [15:0] SCDS_CTRL_OFFSET = 16'hff44;
    localparam logic [15:0] SCDS_STAT_OFFSET = 16'hff45;
    localparam logic [7:0] SCDS_RESET_VALUE = 8'h88;
    localparam logic [7:0] SCDS_CTRL_RESET = 8'h00;
    localparam int SCDS_CH0_LSB = 0;
    localparam int SCDS_CH1_LSB = 4;
    localparam int SCDS_CODE_W = 4;
    localparam logic [3:0] SCDS_CODE_MIN = 4'h6;
    localparam logic [3:0] SCDS_CODE_MAX = 4'hd;
    localparam logic [3:0] SCDS_I2C_EXTRA = 4'h4;
    localparam int SCDS_CTRL_HALVE_BIT = 0;
    localparam int SCDS_CTRL_I2C_BIT = 1;
    localparam int SCDS_CTRL_BUSY_BIT = 2;
    localparam int SCDS_CTRL_CH0_EN_BIT = 3;
    localparam int SCDS_CTRL_CH1_EN_BIT = 4;
    localparam int SCDS_DIV_W = 13;
    localparam logic [3:0] SCDS_EXP_BASE = 4'h5;
endpackage

/* scds_divider.sv */
// power-of-two divider that makes one enable pulse per period
// assumes a synchronous reset copy and a legal exponent
`timescale 1ns/1ps
`default_nettype none
module scds_divider #(
    parameter int DIV_W = 13
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic src_tick,
    input wire logic [3:0] exponent,
    output logic tick
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic [DIV_W-1:0] last;
    logic next_tick;

    always_comb begin
        last = (DIV_W'(1) << exponent) - DIV_W'(1);
        next_count = count;
        next_tick = 1'b0;
        if (!enable) begin
            next_count = '0;
        end else if (src_tick) begin
            if (count >= last) begin
                next_count = '0;
                next_tick = 1'b1;
            end else begin
                next_count = count + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule // scds_divider
`default_nettype wire

/* scds_top.sv */
// clock select register with two channel shift clock dividers
// assumes clk is the oscillator and wishbone classic slave access
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - low nibble picks channel 0 divider
// - high nibble picks channel 1 divider
// - base clock is oscillator or half
// - i2c mode shifts channel 0 range
module scds_top #(
    parameter int DIV_W = scds_pkg::SCDS_DIV_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic ch0_shift_tick,
    output logic ch1_shift_tick
);
    import scds_pkg::*;

    logic rst_meta;
    logic rst_n;
    logic [7:0] serial_clock_divider_select;
    logic [7:0] next_select;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] next_dat;
    logic next_ack;
    logic next_err;
    logic half_phase;
    logic next_half_phase;
    logic base_tick;
    logic [3:0] ch0_exp;
    logic [3:0] ch1_exp;
    logic ch0_ok;
    logic ch1_ok;
    logic ch0_run;
    logic ch1_run;
    logic req;
    logic main_clock_halving_select;

    function automatic logic code_legal(input logic [3:0] code, input logic halving_off);
        code_legal = (code >= SCDS_CODE_MIN) && (code <= SCDS_CODE_MAX) &&
                     !(halving_off && code == SCDS_CODE_MIN);
    endfunction

    function automatic logic [3:0] code_exp(input logic [3:0] code);
        code_exp = code - SCDS_EXP_BASE;
    endfunction

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // bit set selects fxx = fx, clear selects fx/2
    assign main_clock_halving_select = ctrl[SCDS_CTRL_HALVE_BIT];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // register bus decode, one answer per request
    always_comb begin
        next_select = serial_clock_divider_select;
        next_ctrl = ctrl;
        next_dat = wb_dat_o;
        next_ack = 1'b0;
        next_err = 1'b0;
        if (req) begin
            if (wb_adr_i == SCDS_REG_OFFSET) begin
                next_ack = 1'b1;
                next_dat = serial_clock_divider_select;
                if (wb_we_i && wb_sel_i) begin
                    next_select = wb_dat_i;
                end
            end else if (wb_adr_i == SCDS_CTRL_OFFSET) begin
                next_ack = 1'b1;
                next_dat = ctrl;
                if (wb_we_i && wb_sel_i) begin
                    next_ctrl = {3'h0, wb_dat_i[SCDS_CTRL_CH1_EN_BIT:SCDS_CTRL_CH0_EN_BIT], 1'b0,
                                 wb_dat_i[SCDS_CTRL_I2C_BIT:SCDS_CTRL_HALVE_BIT]};
                end
            end else if (wb_adr_i == SCDS_STAT_OFFSET) begin
                next_ack = 1'b1;
                next_dat = {4'h0, ch1_ok, ch0_ok, ch1_run, ch0_run};
            end else begin
                next_err = 1'b1;
                next_dat = 8'h00;
            end
        end
    end

    // registered bus answer and register state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_clock_divider_select <= SCDS_RESET_VALUE;
            ctrl <= SCDS_CTRL_RESET;
            wb_dat_o <= 8'h00;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            serial_clock_divider_select <= next_select;
            ctrl <= next_ctrl;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
            wb_err_o <= next_err;
        end
    end

    // main system clock tick: every cycle or every other cycle
    always_comb begin
        next_half_phase = main_clock_halving_select ? 1'b0 : !half_phase;
        base_tick = main_clock_halving_select || half_phase;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= next_half_phase;
        end
    end

    // codes 6..d map to exponents 1..8, i2c adds four to channel 0 only
    always_comb begin
        ch0_ok = code_legal(serial_clock_divider_select[SCDS_CH0_LSB +: SCDS_CODE_W],
                            main_clock_halving_select);
        ch1_ok = code_legal(serial_clock_divider_select[SCDS_CH1_LSB +: SCDS_CODE_W],
                            main_clock_halving_select);
        ch0_exp = code_exp(serial_clock_divider_select[SCDS_CH0_LSB +: SCDS_CODE_W]);
        if (ctrl[SCDS_CTRL_I2C_BIT]) begin
            ch0_exp = ch0_exp + SCDS_I2C_EXTRA;
        end
        ch1_exp = code_exp(serial_clock_divider_select[SCDS_CH1_LSB +: SCDS_CODE_W]);
        ch0_run = ctrl[SCDS_CTRL_CH0_EN_BIT] && ch0_ok;
        ch1_run = ctrl[SCDS_CTRL_CH1_EN_BIT] && ch1_ok;
    end

    scds_divider #(.DIV_W(DIV_W)) u_ch0 (
        .clk(clk),
        .rst_n(rst_n),
        .enable(ch0_run),
        .src_tick(base_tick),
        .exponent(ch0_exp),
        .tick(ch0_shift_tick)
    );

    scds_divider #(.DIV_W(DIV_W)) u_ch1 (
        .clk(clk),
        .rst_n(rst_n),
        .enable(ch1_run),
        .src_tick(base_tick),
        .exponent(ch1_exp),
        .tick(ch1_shift_tick)
    );

    // register and bus handshake checks
    AST_RESET_VALUE: assert property (@(posedge clk)
        $rose(rst_n) |->
        serial_clock_divider_select == SCDS_RESET_VALUE) else $error("reset value wrong");
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (!rst_n)
        req && wb_we_i && wb_sel_i && wb_adr_i == SCDS_REG_OFFSET |=>
        serial_clock_divider_select == $past(wb_dat_i) && wb_ack_o) else $error("write lost");
    AST_ACK_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o || wb_err_o |=>
        !wb_ack_o && !wb_err_o) else $error("answer held too long");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
        req && wb_adr_i > SCDS_STAT_OFFSET |=>
        wb_err_o && !wb_ack_o) else $error("no error");
    // code to exponent mapping and prohibited code checks
    AST_CH0_EXP: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl[1] |->
        ch0_exp == serial_clock_divider_select[3:0] - 4'h5) else $error("ch0 map");
    AST_CH1_EXP: assert property (@(posedge clk) disable iff (!rst_n)
        ch1_exp ==
        serial_clock_divider_select[7:4] - 4'h5) else $error("ch1 map");
    AST_I2C_EXP: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl[1] |->
        ch0_exp == serial_clock_divider_select[3:0] - 4'h1) else $error("i2c map");
    AST_PROHIBITED_DIV2: assert property (@(posedge clk) disable iff (!rst_n)
        main_clock_halving_select && serial_clock_divider_select[3:0] == 4'h6 |->
        !ch0_ok && !ch0_run) else $error("div2 code accepted at full rate");
    AST_CH1_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        serial_clock_divider_select[7:4] < 4'h6 || serial_clock_divider_select[7:4] > 4'hd |->
        !ch1_ok && !ch1_run) else $error("ch1 prohibited code accepted");
    // base clock and divider output checks
    AST_HALF_RATE: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl[0] && $past(!ctrl[0]) && base_tick |=>
        ctrl[0] || !base_tick) else $error("halving wrong");
    AST_FULL_RATE: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl[0] |->
        base_tick) else $error("full rate wrong");
    AST_ILLEGAL_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        !ch0_ok |=>
        ##1 !ch0_shift_tick) else $error("illegal code ticks");
    AST_CH1_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        !ch1_ok |=>
        ##1 !ch1_shift_tick) else $error("ch1 illegal code ticks");
    AST_DIV_BY_TWO: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl[0] && ch0_run && ch0_exp == 4'h1 && ch0_shift_tick |=>
        !ch0_shift_tick [*3]) else $error("div2 period");

    // main scenario covers
    COV_CH0_TICK: cover property (@(posedge clk) disable iff (!rst_n) ch0_shift_tick);
    COV_CH1_TICK: cover property (@(posedge clk) disable iff (!rst_n) ch1_shift_tick);
    COV_I2C: cover property (@(posedge clk) disable iff (!rst_n) ctrl[1] && ch0_shift_tick);
    COV_ERR: cover property (@(posedge clk) disable iff (!rst_n) wb_err_o);
    COV_PROHIBITED: cover property (@(posedge clk) disable iff (!rst_n) ctrl[3] && !ch0_ok);
endmodule // scds_top
`default_nettype wire

/* serial_clock_divider_select_bench.sv */
// self-checking bench for the clock select register and the two shift clock dividers
// assumes scds_pkg and scds_top are compiled first; clk is the oscillator at 10 MHz
`timescale 1ns/1ps
`default_nettype none
module serial_clock_divider_select_bench;
    import scds_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [7:0] wb_dat_i = 8'h00;
    logic wb_we_i = 1'b0;
    logic wb_sel_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [7:0] wb_dat_o;
    logic wb_ack_o, wb_err_o, ch0_shift_tick, ch1_shift_tick;
    logic [7:0] rd;
    logic ak, er;
    int n_fail = 0;
    int tests_run = 0;
    int seed = 47;
    always #50 clk = ~clk;
    scds_top u_dut (.clk(clk), .resetn(resetn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .ch0_shift_tick(ch0_shift_tick), .ch1_shift_tick(ch1_shift_tick));
    // reference period in clocks, 0 where no ticks may appear
    function automatic int per(input int c, input int h, input int i2c);
        if (c < 6 || c > 13 || (c == 6 && h != 0)) return 0;
        return (1 << (c - 5 + (i2c != 0 ? 4 : 0))) * (h != 0 ? 1 : 2);
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_per(input int got, input int exp, input string what);
        tests_run++;
        if (got != exp) begin
            n_fail++;
            $display("ERROR at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    // one classic cycle, held until ack or err is sampled high
    task automatic wb(input logic we, input logic sel, input logic [15:0] adr, input logic [7:0] dat);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        ak = wb_ack_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // cycles between two successive ticks, 0 if fewer than two appear
    task automatic measure(input int ch, input int exp, output int got);
        int n;
        int start;
        got = 0;
        start = -1;
        for (n = 0; n < 3 * exp + 40 && got == 0; n++) begin
            @(posedge clk);
            if ((ch != 0 ? ch1_shift_tick : ch0_shift_tick) === 1'b1) begin
                if (start >= 0) got = n - start;
                else start = n;
            end
        end
    endtask
    task automatic results();
        $display("tests_run %0d n_fail %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        $display("ERROR at %0t: watchdog expired", $time);
        results();
    end
    initial begin
        logic [7:0] d;
        logic lg;
        int g;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        wb(1'b0, 1'b1, SCDS_REG_OFFSET, 8'h00);
        chk_byte(rd, 8'h88, "select reset");
        wb(1'b0, 1'b1, SCDS_CTRL_OFFSET, 8'h00);
        chk_byte(rd, SCDS_CTRL_RESET, "ctrl reset");
        d = 8'($random(seed));
        wb(1'b1, 1'b1, SCDS_REG_OFFSET, d);
        wb(1'b1, 1'b0, SCDS_REG_OFFSET, ~d);
        wb(1'b0, 1'b1, SCDS_REG_OFFSET, 8'h00);
        chk_byte(rd, d, "select readback");
        wb(1'b0, 1'b1, 16'hff46, 8'h00);
        chk_byte({6'h00, ak, er}, 8'h01, "unmapped read");
        chk_byte(rd, 8'h00, "unmapped data");
        wb(1'b1, 1'b1, SCDS_STAT_OFFSET, 8'hff);
        chk_byte({7'h00, ak}, 8'h01, "status write acked");
        wb(1'b1, 1'b1, SCDS_CTRL_OFFSET, d);
        wb(1'b0, 1'b1, SCDS_CTRL_OFFSET, 8'h00);
        chk_byte(rd, d & 8'h1b, "ctrl readback");
        wb(1'b1, 1'b1, SCDS_CTRL_OFFSET, 8'h00);
        wb(1'b1, 1'b1, SCDS_REG_OFFSET, {4'h8, d[3:0]});
        wb(1'b0, 1'b1, SCDS_REG_OFFSET, 8'h00);
        chk_byte(rd, {4'h8, d[3:0]}, "fixed high nibble");
        $display("test register access done");
        for (int h = 0; h < 2; h++) begin
            for (int i = 0; i < 2; i++) begin
                for (int c = 5; c < 15; c++) begin
                    wb(1'b1, 1'b1, SCDS_CTRL_OFFSET, {7'h00, h[0]});
                    wb(1'b1, 1'b1, SCDS_REG_OFFSET, {c[3:0], c[3:0]});
                    wb(1'b1, 1'b1, SCDS_CTRL_OFFSET, {3'b000, 1'b1, 1'b1, 1'b0, i[0], h[0]});
                    wb(1'b0, 1'b1, SCDS_STAT_OFFSET, 8'h00);
                    lg = (per(c, h, 0) != 0);
                    chk_byte(rd, {4'h0, lg, lg, lg, lg}, "status flags");
                    measure(0, per(c, h, i), g);
                    chk_per(g, per(c, h, i), "ch0 period");
                    measure(1, per(c, h, 0), g);
                    chk_per(g, per(c, h, 0), "ch1 period");
                    $display("test code %0d halve %0d i2c %0d done", c, h, i);
                end
            end
        end
        results();
    end
endmodule // serial_clock_divider_select_bench
`default_nettype wire
